// ### core/ppo_pkg.sv
package ppo_pkg;

    // register map, byte addresses on a 32-bit wishbone port
    localparam int         ADDR_W       = 4;
    localparam logic [3:0] OFS_IO_CTRL  = 4'h0;
    localparam logic [3:0] OFS_MOD_CTRL = 4'h4;
    localparam logic [3:0] OFS_UNLOCK   = 4'h8;
    localparam logic [3:0] OFS_STATUS   = 4'hc;

    // pin i/o control word field positions
    localparam int IO_OWN_H   = 15;
    localparam int IO_OWN_L   = 14;
    localparam int IO_POL_H   = 13;
    localparam int IO_POL_L   = 12;
    localparam int IO_MODE_HI = 11;
    localparam int IO_MODE_LO = 10;
    localparam int IO_OVREN_H = 9;
    localparam int IO_OVREN_L = 8;
    localparam int IO_OVRD_HI = 7;
    localparam int IO_OVRD_LO = 6;
    localparam int IO_FLTD_HI = 5;
    localparam int IO_FLTD_LO = 4;
    localparam int IO_CLD_HI  = 3;
    localparam int IO_CLD_LO  = 2;

    localparam logic [15:0] IO_CTRL_RST  = 16'h0000;
    localparam logic [15:0] IO_CTRL_MASK = 16'hfffc;

    // module control word field positions
    localparam int         MC_ENABLE    = 0;
    localparam int         MC_FAULT_MODE_SELECT    = 1;
    localparam int         MC_CURRENT_LIMIT_MODE_SELECT     = 2;
    localparam int         MC_LOCK      = 3;
    localparam logic [3:0] MOD_CTRL_RST = 4'h0;

    // status word field positions
    localparam int ST_LOW_OUT  = 0;
    localparam int ST_HIGH_OUT = 1;
    localparam int ST_FAULT    = 2;
    localparam int ST_CLIM     = 3;
    localparam int ST_PHASE    = 4;
    localparam int ST_OPEN     = 5;
    localparam int ST_REFUSED  = 6;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

    // pin index inside two-bit pin vectors
    localparam int PIN_LOW  = 0;
    localparam int PIN_HIGH = 1;

    typedef enum logic [1:0] {
        PPO_COMPLEMENTARY = 2'b00,
        PPO_REDUNDANT     = 2'b01,
        PPO_PUSH_PULL     = 2'b10,
        PPO_INDEPENDENT   = 2'b11
    } ppo_mode_t;

    typedef enum logic [1:0] {
        UNL_LOCKED,
        UNL_HALF,
        UNL_OPEN
    } ppo_unlock_t;

endpackage

// ### core/ppo_pin_if.sv
interface ppo_pin_if;
    import ppo_pkg::*;

    ppo_mode_t  mode;
    logic       pushPhase;
    logic [1:0] genActive;
    logic [1:0] pairActive;
    logic [1:0] owner;
    logic [1:0] polarity;
    logic [1:0] ovrEnable;
    logic [1:0] ovrData;
    logic [1:0] faultData;
    logic [1:0] climData;
    logic       faultForce;
    logic       climForce;
    logic [1:0] gpioLevel;
    logic [1:0] pinLevel;

    modport ctrl (output mode, pushPhase, genActive, owner, polarity, ovrEnable, ovrData,
                  output faultData, climData, faultForce, climForce, gpioLevel, input pinLevel);
    modport pair (input mode, pushPhase, genActive, output pairActive);
    modport stage (input pairActive, owner, polarity, ovrEnable, ovrData, faultData, climData,
                   input faultForce, climForce, gpioLevel, output pinLevel);
endinterface

// ### core/ppo_pair_map.sv
module ppo_pair_map
    import ppo_pkg::*;
(
    ppo_pin_if.pair pins   // mode and generator levels in, per-pin active levels out
);

    logic [1:0] act;

    // spread the generator levels over the pin pair, all in active terms
    always_comb begin
        act = 2'b00;
        unique case (pins.mode)
            PPO_COMPLEMENTARY: begin
                act[PIN_HIGH] = pins.genActive[PIN_HIGH];
                act[PIN_LOW]  = ~pins.genActive[PIN_HIGH];
            end
            PPO_REDUNDANT: begin
                act[PIN_HIGH] = pins.genActive[PIN_HIGH];
                act[PIN_LOW]  = pins.genActive[PIN_HIGH];
            end
            PPO_PUSH_PULL: begin
                // one pin per period, the other held inactive
                act[PIN_HIGH] = pins.genActive[PIN_HIGH] & ~pins.pushPhase;
                act[PIN_LOW]  = pins.genActive[PIN_HIGH] & pins.pushPhase;
            end
            PPO_INDEPENDENT: begin
                act = pins.genActive;
            end
        endcase
    end

    assign pins.pairActive = act;

endmodule

// ### core/ppo_pin_stage.sv
module ppo_pin_stage
    import ppo_pkg::*;
(
    ppo_pin_if.stage pins   // per-pin configuration in, pin levels out
);

    // same logic for the low pin (index 0) and the high pin (index 1)
    for (genvar i = 0; i < 2; i++) begin : g_pin
        wire forcedAct;
        wire pinLvl;

        // fault outranks current limit, which outranks software override
        assign forcedAct = pins.faultForce ? pins.faultData[i] :
                           pins.climForce  ? pins.climData[i]  :
                           pins.ovrEnable[i] ? pins.ovrData[i] :
                           pins.pairActive[i];
        // forced values are active/inactive, inversion comes after them
        assign pinLvl = forcedAct ^ pins.polarity[i];
        assign pins.pinLevel[i] = pins.owner[i] ? pinLvl : pins.gpioLevel[i];
    end

endmodule

// ### core/ppo_output_ctrl.sv
module ppo_output_ctrl
    import ppo_pkg::*;
(
    input  wire logic              clock,          // 100 MHz module clock
    input  wire logic              nrst,           // synchronous reset, active low
    input  wire logic              wb_cyc_i,       // wishbone cycle
    input  wire logic              wb_stb_i,       // wishbone strobe
    input  wire logic              wb_we_i,        // wishbone write enable
    input  wire logic [ADDR_W-1:0] wb_adr_i,       // wishbone byte address
    input  wire logic [3:0]        wb_sel_i,       // wishbone byte lanes
    input  wire logic [31:0]       wb_dat_i,       // wishbone write data
    output logic      [31:0]       wb_dat_o,       // wishbone read data
    output logic                   wb_ack_o,       // wishbone acknowledge
    input  wire logic              genHighActive,  // generator high-side active level
    input  wire logic              genLowActive,   // generator low-side active level
    input  wire logic              periodStart,    // generator period start pulse
    input  wire logic              faultActive,    // fault detector level
    input  wire logic              climActive,     // current-limit detector level
    input  wire logic              gpioHighLevel,  // gpio port level for high pin
    input  wire logic              gpioLowLevel,   // gpio port level for low pin
    output logic                   highSideOutput, // high-side pin
    output logic                   lowSideOutput,  // low-side pin
    output logic                   highPinOwned,   // high pin owned by pwm path
    output logic                   lowPinOwned     // low pin owned by pwm path
);

    // register state
    logic [15:0] ioCtrl_r;
    logic [15:0] ioCtrl_nxt;
    logic [3:0]  modCtrl_r;
    logic [3:0]  modCtrl_nxt;
    ppo_unlock_t unlock_r;
    ppo_unlock_t unlock_nxt;
    logic        refused_r;
    logic        refused_nxt;
    logic        phase_r;
    logic        phase_nxt;
    logic        ack_r;
    logic [31:0] rdData_r;
    logic        highOut_r;
    logic        lowOut_r;
    logic        highOwn_r;
    logic        lowOwn_r;

    ppo_pin_if pins ();

    // bus decode
    wire busReq  = wb_cyc_i & wb_stb_i & ~ack_r;
    wire wrReq   = busReq & wb_we_i;
    wire selIo   = (wb_adr_i == OFS_IO_CTRL);
    wire selMod  = (wb_adr_i == OFS_MOD_CTRL);
    wire selKey  = (wb_adr_i == OFS_UNLOCK);
    wire selStat = (wb_adr_i == OFS_STATUS);

    // write gating for the locked control word
    wire lockCfg    = modCtrl_r[MC_LOCK];
    wire isOpen     = (unlock_r == UNL_OPEN);
    wire ioWrTry    = wrReq & selIo & (wb_sel_i[1:0] != 2'b00);
    wire ioWrOk     = ioWrTry & (~lockCfg | isOpen);
    wire ioWrRefuse = ioWrTry & lockCfg & ~isOpen;
    wire modWr      = wrReq & selMod & wb_sel_i[0];
    wire keyWr      = wrReq & selKey & wb_sel_i[0];
    wire statWr     = wrReq & selStat & wb_sel_i[0];
    wire [7:0] key  = wb_dat_i[7:0];

    // control fields
    wire       globalEn = modCtrl_r[MC_ENABLE];
    wire       fltMode  = modCtrl_r[MC_FAULT_MODE_SELECT];
    wire       clMode   = modCtrl_r[MC_CURRENT_LIMIT_MODE_SELECT];
    wire [1:0] modeBits = ioCtrl_r[IO_MODE_HI:IO_MODE_LO];

    // byte-lane merge of the control word write
    wire [15:0] ioWrData = {wb_sel_i[1] ? wb_dat_i[15:8] : ioCtrl_r[15:8],
                            wb_sel_i[0] ? wb_dat_i[7:0]  : ioCtrl_r[7:0]};

    // the mode field is frozen while running: a change mid-run would
    // glitch the pair mapping, so software must not try it
    wire [15:0] modeKeep = 16'h0001 << IO_MODE_LO | 16'h0001 << IO_MODE_HI;
    wire [15:0] ioMerged = globalEn ? ((ioWrData & ~modeKeep) | (ioCtrl_r & modeKeep))
                                    : ioWrData;

    // next value of the control word
    always_comb begin
        ioCtrl_nxt = ioCtrl_r;
        if (ioWrOk) begin
            ioCtrl_nxt = ioMerged & IO_CTRL_MASK;
        end
    end

    // module control: the lock bit is sticky until reset
    always_comb begin
        modCtrl_nxt = modCtrl_r;
        if (modWr) begin
            modCtrl_nxt = wb_dat_i[3:0];
            modCtrl_nxt[MC_LOCK] = modCtrl_r[MC_LOCK] | wb_dat_i[MC_LOCK];
        end
    end

    // unlock sequence: two keys in a row open one control word write
    always_comb begin
        unlock_nxt = unlock_r;
        unique case (unlock_r)
            UNL_LOCKED: begin
                if (keyWr && key == UNLOCK_KEY1) begin
                    unlock_nxt = UNL_HALF;
                end
            end
            UNL_HALF: begin
                if (keyWr) begin
                    unlock_nxt = (key == UNLOCK_KEY2) ? UNL_OPEN : UNL_LOCKED;
                end
            end
            UNL_OPEN: begin
                // a single control write uses up the unlock
                if (ioWrTry) begin
                    unlock_nxt = UNL_LOCKED;
                end else if (keyWr) begin
                    unlock_nxt = (key == UNLOCK_KEY1) ? UNL_HALF : UNL_LOCKED;
                end
            end
            default: begin
                unlock_nxt = UNL_LOCKED;
            end
        endcase
    end

    // refused-write flag: a new refusal wins over a clear in the same cycle
    always_comb begin
        refused_nxt = refused_r;
        if (statWr && wb_dat_i[ST_REFUSED]) begin
            refused_nxt = 1'b0;
        end
        if (ioWrRefuse) begin
            refused_nxt = 1'b1;
        end
    end

    // push-pull phase flips each period while the module runs in push-pull mode
    always_comb begin
        phase_nxt = phase_r;
        if (!globalEn || modeBits != PPO_PUSH_PULL) begin
            phase_nxt = 1'b0;
        end else if (periodStart) begin
            phase_nxt = ~phase_r;
        end
    end

    // pin path configuration
    assign pins.mode       = ppo_mode_t'(modeBits);
    assign pins.pushPhase  = phase_r;
    assign pins.genActive  = {genHighActive, genLowActive};
    assign pins.owner      = {ioCtrl_r[IO_OWN_H], ioCtrl_r[IO_OWN_L]};
    assign pins.polarity   = {ioCtrl_r[IO_POL_H], ioCtrl_r[IO_POL_L]};
    assign pins.ovrEnable  = {ioCtrl_r[IO_OVREN_H], ioCtrl_r[IO_OVREN_L]};
    assign pins.ovrData    = ioCtrl_r[IO_OVRD_HI:IO_OVRD_LO];
    assign pins.faultData  = ioCtrl_r[IO_FLTD_HI:IO_FLTD_LO];
    assign pins.climData   = ioCtrl_r[IO_CLD_HI:IO_CLD_LO];
    assign pins.gpioLevel  = {gpioHighLevel, gpioLowLevel};

    // forcing conditions only count when their mode is selected
    assign pins.faultForce = faultActive & fltMode;
    assign pins.climForce  = climActive & clMode;

    ppo_pair_map u_pair (
        .pins (pins)
    );

    ppo_pin_stage u_stage (
        .pins (pins)
    );

    // read data selection, unmapped addresses read as zero
    wire [31:0] statWord = {25'h0000000, refused_r, isOpen, phase_r,
                            pins.climForce, pins.faultForce, highOut_r, lowOut_r};
    wire [31:0] rdMux = selIo   ? {16'h0000, ioCtrl_r} :
                        selMod  ? {28'h0000000, modCtrl_r} :
                        selStat ? statWord :
                        32'h00000000;

    // register file and bus answer
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ioCtrl_r  <= IO_CTRL_RST;
            modCtrl_r <= MOD_CTRL_RST;
            unlock_r  <= UNL_LOCKED;
            refused_r <= 1'b0;
            phase_r   <= 1'b0;
        end else begin
            ioCtrl_r  <= ioCtrl_nxt;
            modCtrl_r <= modCtrl_nxt;
            unlock_r  <= unlock_nxt;
            refused_r <= refused_nxt;
            phase_r   <= phase_nxt;
        end
    end

    // one wait state; every address answers, so the master never hangs
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ack_r    <= 1'b0;
            rdData_r <= 32'h00000000;
        end else begin
            ack_r    <= busReq;
            rdData_r <= (busReq && !wb_we_i) ? rdMux : 32'h00000000;
        end
    end

    // pin outputs registered so the power stage sees no decode glitches
    always_ff @(posedge clock) begin
        if (!nrst) begin
            highOut_r <= 1'b0;
            lowOut_r  <= 1'b0;
            highOwn_r <= 1'b0;
            lowOwn_r  <= 1'b0;
        end else begin
            highOut_r <= pins.pinLevel[PIN_HIGH];
            lowOut_r  <= pins.pinLevel[PIN_LOW];
            highOwn_r <= pins.owner[PIN_HIGH];
            lowOwn_r  <= pins.owner[PIN_LOW];
        end
    end

    assign wb_ack_o       = ack_r;
    assign wb_dat_o       = rdData_r;
    assign highSideOutput = highOut_r;
    assign lowSideOutput  = lowOut_r;
    assign highPinOwned   = highOwn_r;
    assign lowPinOwned    = lowOwn_r;

endmodule

// ### verification/ppo_stage_model.sv
module ppo_stage_model
(
    input  wire logic clock,           // module clock
    input  wire logic highLeg,         // high-side gate drive level
    input  wire logic lowLeg,          // low-side gate drive level
    input  wire logic armed,           // desaturation sensing on
    output logic      legFault         // shoot-through seen while armed
);
    timeunit 1ns;
    timeprecision 1ps;

    // both legs on shorts the bus; latched so a forced-off pair cannot clear it
    always_ff @(posedge clock) begin
        legFault <= armed && (legFault || (highLeg && lowLeg));
    end
endmodule

// ### verification/ppo_output_ctrl_props.sv
module ppo_output_ctrl_props
    import ppo_pkg::*;
(
    input wire logic              clock,          // module clock
    input wire logic              nrst,           // synchronous reset, active low
    input wire logic              wb_cyc_i,       // bus cycle
    input wire logic              wb_stb_i,       // bus strobe
    input wire logic              wb_we_i,        // bus write enable
    input wire logic [ADDR_W-1:0] wb_adr_i,       // bus address
    input wire logic [31:0]       wb_dat_o,       // read data
    input wire logic              wb_ack_o,       // acknowledge
    input wire logic              gpioHighLevel,  // port level, high pin
    input wire logic              gpioLowLevel,   // port level, low pin
    input wire logic              highSideOutput, // high pin
    input wire logic              lowSideOutput,  // low pin
    input wire logic              highPinOwned,   // high pin owner
    input wire logic              lowPinOwned     // low pin owner
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // request decode; unmapped and key reads must come back blank
    wire logic takeReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rdIo    = takeReq && !wb_we_i && wb_adr_i == OFS_IO_CTRL;
    wire logic rdBlank = takeReq && !wb_we_i && (wb_adr_i[1:0] != 2'h0 || wb_adr_i == OFS_UNLOCK);

    a_ack_follows: assert property (takeReq |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(takeReq))
        else $error("ack without a request");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_blank_read: assert property (wb_ack_o && $past(rdBlank) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_io_shape: assert property (wb_ack_o && $past(rdIo) |-> wb_dat_o[31:16] == 16'h0 && wb_dat_o[1:0] == 2'h0)
        else $error("control word unused bits set");
    a_high_gpio: assert property (!highPinOwned && !$past(highPinOwned) && $past(nrst)
        |-> highSideOutput == $past(gpioHighLevel)) else $error("high pin not from port");
    a_low_gpio: assert property (!lowPinOwned && !$past(lowPinOwned) && $past(nrst)
        |-> lowSideOutput == $past(gpioLowLevel)) else $error("low pin not from port");
    a_reset_quiet: assert property (!$past(nrst) |-> !wb_ack_o && !highPinOwned && !lowPinOwned)
        else $error("outputs not cleared by reset");
endmodule

bind ppo_output_ctrl ppo_output_ctrl_props u_ppo_output_ctrl_props (.clock(clock), .nrst(nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gpioHighLevel(gpioHighLevel), .gpioLowLevel(gpioLowLevel),
    .highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput), .highPinOwned(highPinOwned),
    .lowPinOwned(lowPinOwned));

// ### verification/ppo_output_ctrl_tb.sv
module ppo_output_ctrl_tb
    import ppo_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock = 1'b0, nrst = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [3:0]  wbAdr = 4'h0, wbSel = 4'h0, mc = 4'h0;
    logic [31:0] wbDatI = 32'h0, wbDatO, rd;
    logic        genH = 1'b0, genL = 1'b0, perStart = 1'b0, fltReq = 1'b0, clim = 1'b0;
    logic        gpioH = 1'b0, gpioL = 1'b0, armed = 1'b0, phase = 1'b0, opened = 1'b0;
    logic        wbAck, highOut, lowOut, highOwn, lowOwn, legFault;
    logic [15:0] io = 16'h0;
    int          errors = 0, comparisons = 0;
    wire logic   fltActive = fltReq | legFault;

    always #5 clock = ~clock;

    ppo_output_ctrl u_ppo_output_ctrl (.clock(clock), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .genHighActive(genH), .genLowActive(genL), .periodStart(perStart),
        .faultActive(fltActive), .climActive(clim), .gpioHighLevel(gpioH), .gpioLowLevel(gpioL),
        .highSideOutput(highOut), .lowSideOutput(lowOut), .highPinOwned(highOwn), .lowPinOwned(lowOwn));
    ppo_stage_model u_ppo_stage_model (.clock(clock), .highLeg(highOut), .lowLeg(lowOut), .armed(armed),
        .legFault(legFault));

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle, entered just after a rising edge; read data kept in rd
    task automatic xfer(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] wd);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatI <= wd;
        // ack and read data are taken at the rising edge that samples ack high
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        chk({31'h0, wbAck}, 32'h1);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [3:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 4'hf, 32'h0);
        chk(rd, exp);
    endtask

    // shadow: mode frozen while enabled, locked writes dropped unless opened
    task automatic wio(input logic [15:0] v);
        xfer(1'b1, OFS_IO_CTRL, 4'hf, {16'h0, v});
        if (!mc[MC_LOCK] || opened) io = mc[MC_ENABLE] ? {v[15:12], io[11:10], v[9:2], 2'b00} : v & IO_CTRL_MASK;
        opened = 1'b0;
    endtask

    task automatic wmc(input logic [3:0] v);
        xfer(1'b1, OFS_MOD_CTRL, 4'hf, {28'h0, v});
        mc = v | {mc[MC_LOCK], 3'b000};
    endtask

    function automatic logic [1:0] expPins();
        logic [1:0] act;
        case (io[11:10])
            2'b00:   act = {genH, ~genH};
            2'b01:   act = {genH, genH};
            2'b10:   act = phase ? {1'b0, genH} : {genH, 1'b0};
            default: act = {genH, genL};
        endcase
        if (io[IO_OVREN_H]) act[1] = io[IO_OVRD_HI];
        if (io[IO_OVREN_L]) act[0] = io[IO_OVRD_LO];
        if (mc[MC_CURRENT_LIMIT_MODE_SELECT] && clim) act = io[3:2];
        if (mc[MC_FAULT_MODE_SELECT] && fltActive) act = io[5:4];
        act = act ^ io[13:12];
        return {io[IO_OWN_H] ? act[1] : gpioH, io[IO_OWN_L] ? act[0] : gpioL};
    endfunction

    // pins are registered, so three edges cover any input or register change
    task automatic pins();
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk({28'h0, highOwn, lowOwn, highOut, lowOut}, {28'h0, io[IO_OWN_H], io[IO_OWN_L], expPins()});
        @(posedge clock);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rdchk(OFS_IO_CTRL, 32'h0);
        rdchk(OFS_MOD_CTRL, 32'h0);
        gpioH <= 1'b1;
        pins();
        gpioH <= 1'b0;
        gpioL <= 1'b1;
        pins();
        // masking, lane select and an unmapped place
        wio(16'hffff);
        rdchk(OFS_IO_CTRL, 32'h0000fffc);
        xfer(1'b1, OFS_IO_CTRL, 4'h1, 32'h0);
        io = {io[15:8], 8'h00};
        xfer(1'b1, 4'h2, 4'hf, 32'h0000ffff);
        rdchk(4'h2, 32'h0);
        rdchk(OFS_IO_CTRL, 32'h0000ff00);
        // every mode and polarity against every generator level
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 4; p++) begin
                wio({2'b11, 2'(p), 2'(m), 10'h0});
                for (int g = 0; g < 4; g++) begin
                    genH <= g[1];
                    genL <= g[0];
                    pins();
                end
            end
        end
        for (int d = 0; d < 16; d++) begin
            wio({2'b11, 2'b01, 2'b11, 4'(d), 6'h0});
            pins();
        end
        // fault beats limit beats override, both polarities
        wmc(4'h6);
        for (int k = 0; k < 8; k++) begin
            if (k[1:0] == 2'b00) wio(k[2] ? 16'hff98 : 16'hcf98);
            fltReq <= k[1];
            clim <= k[0];
            pins();
        end
        wmc(4'h0);
        pins();
        fltReq <= 1'b0;
        clim <= 1'b0;
        // the stage trips the fault path on shoot-through
        wmc(4'h2);
        wio(16'hcc00);
        armed <= 1'b1;
        pins();
        armed <= 1'b0;
        pins();
        // push-pull phase, and the mode frozen while enabled
        wio(16'hc800);
        wmc(4'h1);
        pins();
        perStart <= 1'b1;
        @(posedge clock);
        perStart <= 1'b0;
        phase = 1'b1;
        pins();
        wio(16'hc000);
        rdchk(OFS_IO_CTRL, 32'h0000c800);
        wmc(4'h0);
        phase = 1'b0;
        // lock, refusal flag and the unlock keys
        wmc(4'h8);
        wio(16'h4000);
        rdchk(OFS_IO_CTRL, 32'h0000c800);
        xfer(1'b0, OFS_STATUS, 4'hf, 32'h0);
        chk({31'h0, rd[ST_REFUSED]}, 32'h1);
        xfer(1'b1, OFS_STATUS, 4'h1, 32'h00000040);
        xfer(1'b0, OFS_STATUS, 4'hf, 32'h0);
        chk({31'h0, rd[ST_REFUSED]}, 32'h0);
        xfer(1'b1, OFS_UNLOCK, 4'h1, {24'h0, UNLOCK_KEY1});
        xfer(1'b1, OFS_UNLOCK, 4'h1, {24'h0, UNLOCK_KEY2});
        opened = 1'b1;
        // a status read must not use up the unlock
        xfer(1'b0, OFS_STATUS, 4'hf, 32'h0);
        chk({31'h0, rd[ST_OPEN]}, 32'h1);
        rdchk(OFS_UNLOCK, 32'h0);
        wio(16'h4000);
        rdchk(OFS_IO_CTRL, 32'h00004000);
        wio(16'h8000);
        rdchk(OFS_IO_CTRL, 32'h00004000);
        print_verdict();
    end

    // the run needs about six hundred cycles; over thirty times that means a hang
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        print_verdict();
    end
endmodule
